// ==== rtl/catc_cfg.svh ====
`ifndef CATC_CFG_SVH
`define CATC_CFG_SVH
// Register byte offsets.
`define CATC_OFS_FRAME_HZ 8'h00
`define CATC_OFS_FRAME_UNITS 8'h04
`define CATC_OFS_LINE_HZ 8'h08
`define CATC_OFS_LEGACY_LINE_HZ 8'h0C
`define CATC_OFS_LINE_UNITS 8'h10
`define CATC_OFS_STATE_SEL 8'h14
`define CATC_OFS_STATE_VAL 8'h18
`define CATC_OFS_TRIG_SEL 8'h1C
`define CATC_OFS_TRIG_CFG 8'h20
`define CATC_OFS_TRIG_SW 8'h24
`define CATC_OFS_TRIG_DELAY 8'h28
`define CATC_OFS_TRIG_RATIO 8'h2C
`define CATC_OFS_CTRL 8'h30
`define CATC_OFS_EXPO_TIME 8'h34
`define CATC_OFS_OVERLAP_AFTER_EXPOSURE_TIME 8'h38
// Field positions.
`define CATC_CFG_EN_BIT 0
`define CATC_CFG_ORIG_LSB 4
`define CATC_CFG_QUAL_LSB 8
`define CATC_CFG_OVL_LSB 12
`define CATC_RATIO_UP_LSB 8
`define CATC_CTRL_RUN_BIT 0
// Reset values.
`define CATC_RST_FRAME_HZ 32'h0000_001E
`define CATC_RST_LINE_HZ 32'h0000_2710
`define CATC_RST_EXPO 32'h0000_0064
`define CATC_RST_OVERLAP_AFTER_EXPOSURE 32'h0000_00C8
`define CATC_RST_RATIO 16'h0101
// Clock rate in hertz.
`define CATC_CLK_HZ 100_000_000
`endif

// ==== rtl/catc_pkg.sv ====
package catc_pkg;
   // Trigger types, also the index into per-trigger storage.
   typedef enum logic [3:0] {
      TT_ACQ_BEGIN = 4'h0, TT_ACQ_FINISH = 4'h1, TT_ACQ_ACTIVE = 4'h2,
      TT_FRAME_BEGIN = 4'h3, TT_FRAME_FINISH = 4'h4,
      TT_FRAME_ACTIVE = 4'h5, TT_LINE_BEGIN = 4'h6,
      TT_EXPO_BEGIN = 4'h7, TT_EXPO_FINISH = 4'h8, TT_EXPO_ACTIVE = 4'h9
   } catc_trig_e;
   typedef enum logic [2:0] {
      EDGE_UP = 3'h0, EDGE_DOWN = 3'h1, EDGE_EITHER = 3'h2,
      LEVEL_ONE = 3'h3, LEVEL_ZERO = 3'h4
   } catc_qual_e;
   typedef enum logic [1:0] {
      OVERLAP_OFF = 2'h0, OVERLAP_AFTER_EXPOSURE = 2'h1,
      OVERLAP_AFTER_PRIOR_BEGIN = 2'h2
   } catc_ovl_e;
   typedef enum logic [3:0] {
      FS_IDLE = 4'b0001, FS_WAIT = 4'b0010, FS_EXPOSE = 4'b0100,
      FS_OVERLAP_AFTER_EXPOSURE = 4'b1000
   } catc_fstate_e;
   // Per-trigger settings.
   typedef struct packed {
      logic trigEnable;
      logic [3:0] trigOriginSelect;
      catc_qual_e trigQualifier;
      catc_ovl_e trigOverlapPolicy;
   } catc_trig_cfg_s;
   // Hardware trigger sources; origin code n selects bit n-1.
   typedef struct packed {
      logic actionCmd;
      logic [1:0] userOutBit;
      logic [1:0] counterFinishEvent;
      logic [1:0] counterBeginEvent;
      logic [1:0] timerFinishEvent;
      logic [1:0] timerBeginEvent;
      logic [3:0] inputLine;
   } catc_src_s;
   // Seven state signals, selector code equals bit index.
   typedef struct packed {
      logic exposureInProgress;
      logic frameTransferring;
      logic frameInProgress;
      logic frameWaitingForTrigger;
      logic acqTransferring;
      logic acqInProgress;
      logic acqWaitingForTrigger;
   } catc_state_s;
endpackage : catc_pkg

// ==== rtl/catc_acq_trigger.sv ====
`timescale 1ns/10ps
`include "catc_cfg.svh"
module catc_acq_trigger #(
   parameter int CLK_HZ = `CATC_CLK_HZ,
   parameter int NUM_TRIG = 10,
   parameter int DLY_W = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Trigger sources, asynchronous.
   input wire catc_pkg::catc_src_s trigSources,
   // Block outputs.
   output catc_pkg::catc_state_s stateSignals,
   output logic [NUM_TRIG-1:0] trigFire,
   output logic lineStrobe
);
   import catc_pkg::*;

   localparam int SRC_W = $bits(catc_src_s);

   // Ten trigger types and a four-bit origin field are assumed throughout.
   initial
   begin
      if (NUM_TRIG != 10 || SRC_W > 15 || DLY_W < 1 || DLY_W > 32)
         $error("catc_acq_trigger: unsupported parameter values");
   end

   // Register state.
   logic [31:0] frameHz_r, frameUnits_r, lineHz_r, lineUnits_r;
   logic [31:0] expoTime_r, readoutTime_r;
   logic [2:0] stateSel_r;
   logic [3:0] trigSel_r;
   logic runCtrl_r;
   catc_trig_cfg_s trigCfg_r [NUM_TRIG];
   logic [DLY_W-1:0] trigDelay_r [NUM_TRIG];
   logic [7:0] ratioDown_r [NUM_TRIG];
   logic [7:0] ratioUp_r [NUM_TRIG];
   logic [NUM_TRIG-1:0] swPulse_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   // Bus decode.
   wire setup = psel & ~penable;
   wire wrAcc = psel & penable & pwrite;
   wire hitFrameHz = paddr == `CATC_OFS_FRAME_HZ;
   wire hitFrameUnits = paddr == `CATC_OFS_FRAME_UNITS;
   wire hitLineHz = paddr == `CATC_OFS_LINE_HZ ||
                    paddr == `CATC_OFS_LEGACY_LINE_HZ;
   wire hitLineUnits = paddr == `CATC_OFS_LINE_UNITS;
   wire hitStateSel = paddr == `CATC_OFS_STATE_SEL;
   wire hitStateVal = paddr == `CATC_OFS_STATE_VAL;
   wire hitTrigSel = paddr == `CATC_OFS_TRIG_SEL;
   wire hitTrigCfg = paddr == `CATC_OFS_TRIG_CFG;
   wire hitTrigSw = paddr == `CATC_OFS_TRIG_SW;
   wire hitTrigDelay = paddr == `CATC_OFS_TRIG_DELAY;
   wire hitTrigRatio = paddr == `CATC_OFS_TRIG_RATIO;
   wire hitCtrl = paddr == `CATC_OFS_CTRL;
   wire hitExpo = paddr == `CATC_OFS_EXPO_TIME;
   wire hitReadout = paddr == `CATC_OFS_OVERLAP_AFTER_EXPOSURE_TIME;
   wire hitAny = hitFrameHz | hitFrameUnits | hitLineHz | hitLineUnits |
                 hitStateSel | hitStateVal | hitTrigSel | hitTrigCfg |
                 hitTrigSw | hitTrigDelay | hitTrigRatio | hitCtrl |
                 hitExpo | hitReadout;
   // Writing the trigger selector above nine is refused by keeping the old.
   wire trigSelOk = trigSel_r < 4'(NUM_TRIG);
   wire [3:0] ts = trigSelOk ? trigSel_r : 4'h0;

   // Sequencer state, declared early for the read mux.
   catc_fstate_e fstate_r;
   logic acqWait_r, acqRun_r, pend_r;
   logic [31:0] phaseCnt_r;
   catc_state_s stateNow;

   // Selected state signal; reading it changes nothing.
   wire [6:0] stateVec = stateNow;
   wire stateValue = (stateSel_r < 3'h7) ? stateVec[stateSel_r]
                                         : 1'b0;

   // Read data for all registers but the software trigger one, which reads zero; per-trigger fields come from the selected entry.
   logic [31:0] rdMux;
   always_comb
   begin
      rdMux = 32'h0000_0000;
      if (hitFrameHz) rdMux = frameHz_r;
      if (hitFrameUnits) rdMux = frameUnits_r;
      if (hitLineHz) rdMux = lineHz_r;
      if (hitLineUnits) rdMux = lineUnits_r;
      if (hitStateSel) rdMux = {29'h0, stateSel_r};
      if (hitStateVal) rdMux = {17'h0, stateVec, 7'h0, stateValue};
      if (hitTrigSel) rdMux = {28'h0, trigSel_r};
      if (hitTrigCfg)
      begin
         rdMux[`CATC_CFG_EN_BIT] = trigCfg_r[ts].trigEnable;
         rdMux[`CATC_CFG_ORIG_LSB +: 4] = trigCfg_r[ts].trigOriginSelect;
         rdMux[`CATC_CFG_QUAL_LSB +: 3] = trigCfg_r[ts].trigQualifier;
         rdMux[`CATC_CFG_OVL_LSB +: 2] = trigCfg_r[ts].trigOverlapPolicy;
      end
      if (hitTrigDelay) rdMux[DLY_W-1:0] = trigDelay_r[ts];
      if (hitTrigRatio) rdMux[15:0] = {ratioUp_r[ts], ratioDown_r[ts]};
      if (hitCtrl) rdMux[`CATC_CTRL_RUN_BIT] = runCtrl_r;
      if (hitExpo) rdMux = expoTime_r;
      if (hitReadout) rdMux = readoutTime_r;
   end

   // Answer is taken at the setup cycle so the access cycle has no wait.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (setup)
      begin
         prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
         pslverr_r <= ~hitAny;
      end
   end
   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = pslverr_r;

   // Global registers.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frameHz_r <= `CATC_RST_FRAME_HZ;
         frameUnits_r <= 32'h0000_0000;
         lineHz_r <= `CATC_RST_LINE_HZ;
         lineUnits_r <= 32'h0000_0000;
         expoTime_r <= `CATC_RST_EXPO;
         readoutTime_r <= `CATC_RST_OVERLAP_AFTER_EXPOSURE;
         stateSel_r <= 3'h0;
         trigSel_r <= 4'h0;
         runCtrl_r <= 1'b0;
      end
      else if (wrAcc)
      begin
         if (hitFrameHz) frameHz_r <= pwdata;
         if (hitFrameUnits) frameUnits_r <= pwdata;
         if (hitLineHz) lineHz_r <= pwdata;
         if (hitLineUnits) lineUnits_r <= pwdata;
         if (hitExpo) expoTime_r <= pwdata;
         if (hitReadout) readoutTime_r <= pwdata;
         if (hitStateSel) stateSel_r <= pwdata[2:0];
         if (hitTrigSel && pwdata[3:0] < 4'(NUM_TRIG))
            trigSel_r <= pwdata[3:0];
         if (hitCtrl) runCtrl_r <= pwdata[`CATC_CTRL_RUN_BIT];
      end
   end

   // Two-flop synchroniser, then a third stage for edge history.
   logic [SRC_W-1:0] srcMeta_r, srcSync_r, srcPrev_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         srcMeta_r <= '0;
         srcSync_r <= '0;
         srcPrev_r <= '0;
      end
      else
      begin
         srcMeta_r <= trigSources;
         srcSync_r <= srcMeta_r;
         srcPrev_r <= srcSync_r;
      end
   end

   // Per-trigger storage, qualification, division, delay and multiplication.
   for (genvar i = 0; i < NUM_TRIG; i++)
   begin : g_trig
      wire selMe = ts == 4'(i);
      logic [7:0] divCnt_r, burst_r;
      logic [DLY_W-1:0] dlyCnt_r;
      logic dlyBusy_r;
      wire [3:0] org = trigCfg_r[i].trigOriginSelect;
      wire isSw = org == 4'h0;
      wire [3:0] idx = isSw ? 4'h0 : org - 4'h1;
      wire lvl = (idx < 4'(SRC_W)) ? srcSync_r[idx] : 1'b0;
      wire prv = (idx < 4'(SRC_W)) ? srcPrev_r[idx] : 1'b0;
      logic hwValid;
      always_comb
      begin
         case (trigCfg_r[i].trigQualifier)
            EDGE_UP: hwValid = lvl & ~prv;
            EDGE_DOWN: hwValid = ~lvl & prv;
            EDGE_EITHER: hwValid = lvl ^ prv;
            LEVEL_ONE: hwValid = lvl;
            LEVEL_ZERO: hwValid = ~lvl;
            default: hwValid = 1'b0;
         endcase
      end
      wire valid = trigCfg_r[i].trigEnable &
                   (isSw ? swPulse_r[i] : hwValid);
      wire idle = ~dlyBusy_r & (burst_r == 8'h00);
      wire divHit = divCnt_r + 8'h01 >= ratioDown_r[i];
      wire pass = valid & idle & divHit;
      wire [7:0] upCnt = (ratioUp_r[i] == 8'h00) ? 8'h01 : ratioUp_r[i];

      // Settings for this trigger type.
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
         if (!rst_n)
         begin
            trigCfg_r[i] <= '0;
            trigDelay_r[i] <= '0;
            ratioDown_r[i] <= 8'(`CATC_RST_RATIO);
            ratioUp_r[i] <= 8'(`CATC_RST_RATIO >> `CATC_RATIO_UP_LSB);
            swPulse_r[i] <= 1'b0;
         end
         else
         begin
            swPulse_r[i] <= wrAcc & hitTrigSw & selMe;
            if (wrAcc & selMe & hitTrigCfg)
            begin
               trigCfg_r[i].trigEnable <= pwdata[`CATC_CFG_EN_BIT];
               trigCfg_r[i].trigOriginSelect <=
                  pwdata[`CATC_CFG_ORIG_LSB +: 4];
               trigCfg_r[i].trigQualifier <=
                  catc_qual_e'(pwdata[`CATC_CFG_QUAL_LSB +: 3]);
               trigCfg_r[i].trigOverlapPolicy <=
                  catc_ovl_e'(pwdata[`CATC_CFG_OVL_LSB +: 2]);
            end
            if (wrAcc & selMe & hitTrigDelay)
               trigDelay_r[i] <= pwdata[DLY_W-1:0];
            if (wrAcc & selMe & hitTrigRatio)
            begin
               ratioDown_r[i] <= pwdata[7:0];
               ratioUp_r[i] <= pwdata[`CATC_RATIO_UP_LSB +: 8];
            end
         end
      end

      // Valid events arriving while busy are dropped, not queued.
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
         if (!rst_n)
         begin
            divCnt_r <= 8'h00;
            dlyCnt_r <= '0;
            dlyBusy_r <= 1'b0;
            burst_r <= 8'h00;
         end
         else
         begin
            if (valid & idle)
               divCnt_r <= divHit ? 8'h00 : divCnt_r + 8'h01;
            if (pass && trigDelay_r[i] != '0)
            begin
               dlyBusy_r <= 1'b1;
               dlyCnt_r <= trigDelay_r[i] - 1'b1;
            end
            else if (dlyBusy_r && dlyCnt_r != '0)
               dlyCnt_r <= dlyCnt_r - 1'b1;
            else if (dlyBusy_r)
               dlyBusy_r <= 1'b0;
            if ((pass && trigDelay_r[i] == '0) ||
                (dlyBusy_r && dlyCnt_r == '0))
               burst_r <= upCnt;
            else if (burst_r != 8'h00)
               burst_r <= burst_r - 8'h01;
         end
      end
      assign trigFire[i] = burst_r != 8'h00;

      AST_SW_ONE_PULSE: assert property (@(posedge clk_sys) disable iff
         (!rst_n) swPulse_r[i] |=> !swPulse_r[i])
         else $error("software trigger pulse longer than one cycle");
      AST_DELAY_FIRE: assert property (@(posedge clk_sys) disable iff
         (!rst_n) (pass && trigDelay_r[i] == DLY_W'(16'h0003))
         |=> !trigFire[i] [*3] ##1 trigFire[i])
         else $error("trigger fired at wrong delay");
      AST_DISABLED_QUIET: assert property (@(posedge clk_sys) disable iff
         (!rst_n) (!trigCfg_r[i].trigEnable && idle) |=> !trigFire[i])
         else $error("disabled trigger fired");
   end

   // Free-running rate ticks: a nonzero units period wins over hertz.
   logic [31:0] lineAcc_r, lineCnt_r;
   logic [31:0] frameAcc_r;
   wire [32:0] frameSum = {1'b0, frameAcc_r} + {1'b0, frameHz_r};
   wire [32:0] lineSum = {1'b0, lineAcc_r} + {1'b0, lineHz_r};
   wire frameHzTick = frameSum >= 33'(CLK_HZ);
   wire lineHzTick = lineSum >= 33'(CLK_HZ);
   wire frameUnitsTick = phaseCnt_r + 32'h1 >= frameUnits_r;
   wire lineUnitsTick = lineCnt_r + 32'h1 >= lineUnits_r;
   wire frameTick = (frameUnits_r != 32'h0) ? frameUnitsTick
                                            : frameHzTick;
   wire lineTick = (lineUnits_r != 32'h0) ? lineUnitsTick
                                          : lineHzTick;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frameAcc_r <= 32'h0;
         lineAcc_r <= 32'h0;
         phaseCnt_r <= 32'h0;
         lineCnt_r <= 32'h0;
      end
      else
      begin
         frameAcc_r <= frameHzTick ? 32'(frameSum - 33'(CLK_HZ))
                                   : frameSum[31:0];
         lineAcc_r <= lineHzTick ? 32'(lineSum - 33'(CLK_HZ))
                                 : lineSum[31:0];
         phaseCnt_r <= frameUnitsTick ? 32'h0 : phaseCnt_r + 32'h1;
         lineCnt_r <= lineUnitsTick ? 32'h0 : lineCnt_r + 32'h1;
      end
   end

   // Trigger hooks into the sequencer.
   wire acqBeginEn = trigCfg_r[TT_ACQ_BEGIN].trigEnable;
   wire acqFinishEn = trigCfg_r[TT_ACQ_FINISH].trigEnable;
   wire frameEn = trigCfg_r[TT_FRAME_BEGIN].trigEnable;
   wire lineEn = trigCfg_r[TT_LINE_BEGIN].trigEnable;
   wire expoEndEn = trigCfg_r[TT_EXPO_FINISH].trigEnable;
   catc_ovl_e ovl;
   assign ovl = trigCfg_r[TT_FRAME_BEGIN].trigOverlapPolicy;
   wire fFire = trigFire[TT_FRAME_BEGIN];
   // Overlap windows for latching a frame trigger during a frame.
   wire latchOk = (fstate_r == FS_OVERLAP_AFTER_EXPOSURE && ovl != OVERLAP_OFF) ||
      (fstate_r == FS_EXPOSE && ovl == OVERLAP_AFTER_PRIOR_BEGIN);
   wire pendSet = frameEn & fFire & latchOk & acqRun_r;
   wire startFrame = frameEn ? (fFire | pend_r) : frameTick;

   // Acquisition level state.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acqWait_r <= 1'b0;
         acqRun_r <= 1'b0;
      end
      else if (!runCtrl_r)
      begin
         acqWait_r <= 1'b0;
         acqRun_r <= 1'b0;
      end
      else if (!acqRun_r && !acqWait_r && fstate_r == FS_IDLE)
      begin
         acqWait_r <= acqBeginEn;
         acqRun_r <= ~acqBeginEn;
      end
      else if (acqWait_r && trigFire[TT_ACQ_BEGIN])
      begin
         acqWait_r <= 1'b0;
         acqRun_r <= 1'b1;
      end
      else if (acqRun_r && acqFinishEn && trigFire[TT_ACQ_FINISH])
         acqRun_r <= 1'b0;
   end

   // Frame sequencer with exposure and overlap_after_exposure timers.
   catc_fstate_e fstate_nxt;
   logic [31:0] fcnt_r, fcnt_nxt;
   logic pend_nxt;
   always_comb
   begin
      fstate_nxt = fstate_r;
      fcnt_nxt = (fcnt_r != 32'h0) ? fcnt_r - 32'h1 : 32'h0;
      pend_nxt = pendSet | pend_r; // the clears below override this set
      case (fstate_r)
         FS_IDLE:
            if (acqRun_r) fstate_nxt = FS_WAIT;
         FS_WAIT:
            if (!acqRun_r)
            begin
               fstate_nxt = FS_IDLE;
               pend_nxt = 1'b0;
            end
            else if (startFrame)
            begin
               fstate_nxt = FS_EXPOSE;
               fcnt_nxt = expoTime_r;
               pend_nxt = 1'b0;
            end
         FS_EXPOSE:
            if (fcnt_r == 32'h0 || (expoEndEn && trigFire[TT_EXPO_FINISH]))
            begin
               fstate_nxt = FS_OVERLAP_AFTER_EXPOSURE;
               fcnt_nxt = readoutTime_r;
            end
         FS_OVERLAP_AFTER_EXPOSURE:
            if (fcnt_r == 32'h0)
            begin
               if (acqRun_r && (pend_r || pendSet))
               begin
                  fstate_nxt = FS_EXPOSE;
                  fcnt_nxt = expoTime_r;
               end
               else
                  fstate_nxt = acqRun_r ? FS_WAIT : FS_IDLE;
               pend_nxt = 1'b0;
            end
         default:
            fstate_nxt = FS_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fstate_r <= FS_IDLE;
         fcnt_r <= 32'h0;
         pend_r <= 1'b0;
      end
      else
      begin
         fstate_r <= fstate_nxt;
         fcnt_r <= fcnt_nxt;
         pend_r <= pend_nxt;
      end
   end

   // State signals derived from the sequencer.
   always_comb
   begin
      stateNow.acqWaitingForTrigger = acqWait_r;
      stateNow.acqInProgress = acqRun_r;
      stateNow.acqTransferring = ~acqRun_r & (fstate_r == FS_OVERLAP_AFTER_EXPOSURE);
      stateNow.frameWaitingForTrigger = fstate_r == FS_WAIT;
      stateNow.frameInProgress = fstate_r == FS_EXPOSE ||
                                 fstate_r == FS_OVERLAP_AFTER_EXPOSURE;
      stateNow.frameTransferring = fstate_r == FS_OVERLAP_AFTER_EXPOSURE;
      stateNow.exposureInProgress = fstate_r == FS_EXPOSE;
   end
   assign stateSignals = stateNow;

   // Line strobes run only inside a frame.
   logic lineStrobe_r;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         lineStrobe_r <= 1'b0;
      else
         lineStrobe_r <= stateNow.frameInProgress &
            (lineEn ? trigFire[TT_LINE_BEGIN] : lineTick);
   end
   assign lineStrobe = lineStrobe_r;

   AST_OVERLAP_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (ovl == OVERLAP_OFF && fstate_r == FS_OVERLAP_AFTER_EXPOSURE && fcnt_r == 32'h0)
      |=> fstate_r != FS_EXPOSE)
      else $error("frame trigger overlapped with overlap off");
   AST_EXPO_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ($rose(fstate_r == FS_EXPOSE) && expoTime_r == 32'h2 && !expoEndEn)
      |-> (fstate_r == FS_EXPOSE) [*3] ##1 fstate_r == FS_OVERLAP_AFTER_EXPOSURE)
      else $error("exposure length wrong");
   AST_STATUS_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (setup && hitStateVal && !pwrite && stateSel_r == 3'h6)
      |=> prdata[0] == $past(stateSignals.exposureInProgress))
      else $error("status bit does not follow selector");
   AST_PEND_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ((pend_r || pendSet) && fstate_r == FS_OVERLAP_AFTER_EXPOSURE && fcnt_r == 32'h0 &&
       acqRun_r)
      |=> fstate_r == FS_EXPOSE)
      else $error("latched frame trigger lost");
   AST_FREE_RUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fstate_r == FS_WAIT && acqRun_r && !frameEn && frameTick)
      |=> fstate_r == FS_EXPOSE)
      else $error("free-running frame did not start");
endmodule : catc_acq_trigger

// ==== verification/catc_line_model.sv ====
`timescale 1ns/10ps
// Outside trigger lines: only input line 0 moves, all others rest low.
module catc_line_model (
   // Clock and requested line level.
   input wire logic clk_sys,
   input wire logic lvl,
   // Lines toward the block.
   output catc_pkg::catc_src_s src
);
   import catc_pkg::*;
   // A real line is asynchronous; one edge of lag is harmless here.
   always_ff @(posedge clk_sys)
   begin
      src <= catc_src_s'({14'h0000, lvl});
   end
endmodule : catc_line_model

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`include "catc_cfg.svh"
module tb;
   import catc_pkg::*;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} catc_row_s;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, lvl = 1'b0, pready, pslverr, lineStrobe, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [9:0] trigFire;
   catc_src_s trigSources;
   catc_state_s stateSignals;
   int fail_count = 0, n_compared = 0, np, hi, fst, cy, k;
   bit pv;
   int hwq [3] = '{1, 1, 2};
   int swt [4][4] = '{'{0, 16'h0101, 2, 1}, '{5, 16'h0101, 7, 1},
      '{3, 16'h0101, 5, 1}, '{0, 16'h0301, 2, 3}};
   // Reset values first, then writes that must stick or be refused.
   catc_row_s rows [11] = '{
      '{0, 8'h00, 0, `CATC_RST_FRAME_HZ}, '{0, 8'h08, 0, `CATC_RST_LINE_HZ},
      '{0, 8'h0C, 0, `CATC_RST_LINE_HZ}, '{0, 8'h34, 0, `CATC_RST_EXPO},
      '{0, 8'h38, 0, `CATC_RST_OVERLAP_AFTER_EXPOSURE}, '{0, 8'h2C, 0, 32'h0101},
      '{0, 8'h18, 0, 32'h0}, '{1, 8'h14, 32'h6, 32'h6},
      '{1, 8'h1C, 32'h9, 32'h9}, '{1, 8'h1C, 32'hA, 32'h9},
      '{1, 8'h20, 32'h2311, 32'h2311}};
   always #5 clk_sys = ~clk_sys;
   catc_line_model i_src (.clk_sys(clk_sys), .lvl(lvl), .src(trigSources));
   catc_acq_trigger i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigSources(trigSources), .stateSignals(stateSignals),
      .trigFire(trigFire), .lineStrobe(lineStrobe));
   // One APB transfer; the wait on pready keeps it right for slow slaves.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic clr();
      np = 0;
      hi = 0;
      fst = 0;
      cy = 0;
      pv = 0;
   endtask : clr
   // Counts pulses, high cycles and the cycle of the first pulse.
   task automatic watch(input int b, input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         cy++;
         if (trigFire[b] === 1'b1 && !pv)
            np++;
         if (trigFire[b] === 1'b1 && fst == 0)
            fst = cy;
         if (trigFire[b] === 1'b1)
            hi++;
         pv = trigFire[b] === 1'b1;
      end
   endtask : watch
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // Whole run needs under two thousand cycles.
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      results();
   end
   // Main sequence.
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].w)
            apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk("register", rows[i].e, rd);
      end
      apb(1'b0, 8'h3C, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, er});
      $display("test registers done");
      apb(1'b1, `CATC_OFS_TRIG_SEL, 32'h3);
      apb(1'b1, `CATC_OFS_TRIG_CFG, 32'h1);
      foreach (swt[i])
      begin
         apb(1'b1, `CATC_OFS_TRIG_DELAY, swt[i][0]);
         apb(1'b1, `CATC_OFS_TRIG_RATIO, swt[i][1]);
         clr();
         apb(1'b1, `CATC_OFS_TRIG_SW, 32'h0);
         watch(3, 16);
         chk("fire latency", swt[i][2], fst);
         chk("fire width", swt[i][3], hi);
      end
      apb(1'b1, `CATC_OFS_TRIG_RATIO, 32'h0102);
      clr();
      repeat (4)
      begin
         apb(1'b1, `CATC_OFS_TRIG_SW, 32'h0);
         watch(3, 6);
      end
      chk("divided fires", 2, np);
      apb(1'b1, `CATC_OFS_TRIG_RATIO, 32'h0101);
      apb(1'b1, `CATC_OFS_TRIG_CFG, 32'h0);
      clr();
      apb(1'b1, `CATC_OFS_TRIG_SW, 32'h0);
      watch(3, 8);
      chk("disabled fires", 0, np);
      $display("test software trigger done");
      apb(1'b1, `CATC_OFS_TRIG_SEL, 32'h6);
      foreach (hwq[i])
      begin
         apb(1'b1, `CATC_OFS_TRIG_CFG, 32'h11 | (i << 8));
         clr();
         lvl <= 1'b1;
         watch(6, 12);
         lvl <= 1'b0;
         watch(6, 12);
         chk("edge fires", hwq[i], np);
      end
      apb(1'b1, `CATC_OFS_TRIG_CFG, 32'h311);
      clr();
      lvl <= 1'b1;
      watch(6, 16);
      chk("level refire", 1, np > 1);
      lvl <= 1'b0;
      watch(6, 6);
      clr();
      watch(6, 10);
      chk("level low fires", 0, np);
      apb(1'b1, `CATC_OFS_TRIG_CFG, 32'h411);
      clr();
      watch(6, 10);
      chk("level zero refire", 1, np > 1);
      apb(1'b1, `CATC_OFS_TRIG_CFG, 32'h0);
      $display("test line trigger done");
      apb(1'b1, `CATC_OFS_EXPO_TIME, 32'h2);
      apb(1'b1, `CATC_OFS_FRAME_UNITS, 32'h32);
      apb(1'b1, `CATC_OFS_CTRL, 32'h1);
      while (stateSignals.exposureInProgress !== 1'b1)
         @(posedge clk_sys);
      clr();
      while (stateSignals.exposureInProgress === 1'b1)
      begin
         @(posedge clk_sys);
         cy++;
      end
      chk("exposure length", 3, cy);
      // Overlap_after_exposure is long enough to hold the status read and the strobe window.
      apb(1'b1, `CATC_OFS_LINE_UNITS, 32'h14);
      apb(1'b0, `CATC_OFS_STATE_VAL, 32'h0);
      chk("status", 32'h3200, rd);
      k = 0;
      repeat (40)
      begin
         @(posedge clk_sys);
         k += (lineStrobe === 1'b1);
      end
      chk("line strobes", 2, k);
      $display("test exposure done");
      // A second frame trigger in overlap_after_exposure is latched only with overlap on.
      apb(1'b1, `CATC_OFS_TRIG_SEL, 32'h3);
      for (int p = 1; p >= 0; p--)
      begin
         apb(1'b1, `CATC_OFS_TRIG_CFG, 32'h1 | (p << 12));
         while (stateSignals.frameWaitingForTrigger !== 1'b1)
            @(posedge clk_sys);
         apb(1'b1, `CATC_OFS_TRIG_SW, 32'h0);
         while (stateSignals.frameTransferring !== 1'b1)
            @(posedge clk_sys);
         apb(1'b1, `CATC_OFS_TRIG_SW, 32'h0);
         while (stateSignals.frameTransferring === 1'b1)
            @(posedge clk_sys);
         rd = {30'h0, stateSignals.exposureInProgress,
            stateSignals.frameWaitingForTrigger};
         chk("overlap", p ? 2 : 1, rd);
      end
      $display("test overlap done");
      results();
   end
endmodule : tb
